/* src/sos_regs.sv */
/*
 * sos_regs: register bank for the seven reference-capable outputs, with
 * per-output delay/select and driver registers and one shared enable register.
 * assumes: a serial configuration port outside turns its frames into
 * one-cycle write and read strobes synchronous to CLK_SYS; the global
 * bias-kind bit is held elsewhere and arrives as a level.
 */
// Functional notes
// - source select bit: 0 channel clock, 1 central sysref; resets to 1
// - coarse sysref delay is field value times 169 ps, resets to 0
// - fine delay adds 0..160 ps by table; code split over bits 6,5,0
// - bias applies only while the global bias-kind bit is 1
// - power-down powers output off and ignores format, enable, amplitude
// - format bit 0 selects lvds, 1 selects lvpecl
// - enable 0 holds output static low; 1 passes selected signal
// - per output delay/select and driver registers, one shared enable register
`timescale 1ns/1ps
module sos_regs
	import sos_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// register port
	input wire logic REG_WR_EN,
	input wire logic REG_RD_EN,
	input wire logic [SOS_AW-1:0] REG_ADDR,
	input wire logic [SOS_DW-1:0] REG_WDATA,
	output logic [SOS_DW-1:0] REG_RDATA,
	output logic REG_RVALID,
	// global setting from outside this bank
	input wire logic GLOBAL_BIAS_KIND,
	// per-output controls, bit or slice i = output a0, a1, a2, b0, b1, c, d
	output logic [SOS_NUM_OUT-1:0] OUT_SRC_SYSREF,
	output logic [SOS_NUM_OUT-1:0][SOS_PS_W-1:0] OUT_SYSREF_DELAY_PS,
	output logic [SOS_NUM_OUT-1:0] OUT_POWERED,
	output logic [SOS_NUM_OUT-1:0] OUT_LVPECL,
	output logic [SOS_NUM_OUT-1:0][1:0] OUT_AMPLITUDE,
	output logic [SOS_NUM_OUT-1:0] OUT_PASS,
	output logic [SOS_NUM_OUT-1:0] OUT_BIAS_ON
);

	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	logic [SOS_NUM_OUT-1:0][SOS_DW-1:0] dly_reg;
	logic [SOS_NUM_OUT-1:0][SOS_DW-1:0] drv_reg;
	logic [SOS_DW-1:0] en_reg;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	logic [SOS_IDX_W:0] dly_hit;
	logic [SOS_IDX_W:0] drv_hit;
	logic en_hit;

	assign dly_hit = sos_find(REG_ADDR, SOS_DLY_ADDR);
	assign drv_hit = sos_find(REG_ADDR, SOS_DRV_ADDR);
	assign en_hit = (REG_ADDR == SOS_EN_ADDR);

	// ---------------------------------------------------------------
	// writes
	// ---------------------------------------------------------------
	// reserved bits are masked on the way in, so they can never steer anything
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			for (int i = 0; i < SOS_NUM_OUT; i++) begin
				dly_reg[i] <= SOS_DLY_RESET;
			end
		end else if (REG_WR_EN && dly_hit[SOS_IDX_W]) begin
			dly_reg[dly_hit[SOS_IDX_W-1:0]] <= REG_WDATA & SOS_DLY_MASK;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			for (int i = 0; i < SOS_NUM_OUT; i++) begin
				drv_reg[i] <= SOS_DRV_RESET;
			end
		end else if (REG_WR_EN && drv_hit[SOS_IDX_W]) begin
			drv_reg[drv_hit[SOS_IDX_W-1:0]] <= REG_WDATA & SOS_DRV_MASK;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			en_reg <= SOS_EN_RESET;
		end else if (REG_WR_EN && en_hit) begin
			en_reg <= REG_WDATA & SOS_EN_MASK;
		end
	end

	// ---------------------------------------------------------------
	// reads
	// ---------------------------------------------------------------
	// unmapped addresses answer zero rather than holding the last value
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			REG_RDATA <= '0;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD_EN;
			if (REG_RD_EN) begin
				if (dly_hit[SOS_IDX_W]) begin
					REG_RDATA <= dly_reg[dly_hit[SOS_IDX_W-1:0]];
				end else if (drv_hit[SOS_IDX_W]) begin
					REG_RDATA <= drv_reg[drv_hit[SOS_IDX_W-1:0]];
				end else if (en_hit) begin
					REG_RDATA <= en_reg;
				end else begin
					REG_RDATA <= '0;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// per-output control
	// ---------------------------------------------------------------
	// one instance per output, spelled out so each pin group maps to a named channel
	localparam int IDX_A0 = 0;
	localparam int IDX_A1 = 1;
	localparam int IDX_A2 = 2;
	localparam int IDX_B0 = 3;
	localparam int IDX_B1 = 4;
	localparam int IDX_C = 5;
	localparam int IDX_D = 6;

	sos_out_ctrl u_ctrl_a0 (
		.clk(CLK_SYS),
		.rst(RST),
		.dly_byte(dly_reg[IDX_A0]),
		.drv_byte(drv_reg[IDX_A0]),
		.en_bit(en_reg[SOS_EN_BIT[IDX_A0]]),
		.global_bias_kind(GLOBAL_BIAS_KIND),
		.src_sysref(OUT_SRC_SYSREF[IDX_A0]),
		.delay_ps(OUT_SYSREF_DELAY_PS[IDX_A0]),
		.powered(OUT_POWERED[IDX_A0]),
		.lvpecl(OUT_LVPECL[IDX_A0]),
		.ampl(OUT_AMPLITUDE[IDX_A0]),
		.pass(OUT_PASS[IDX_A0]),
		.bias_on(OUT_BIAS_ON[IDX_A0])
	);

	sos_out_ctrl u_ctrl_a1 (
		.clk(CLK_SYS),
		.rst(RST),
		.dly_byte(dly_reg[IDX_A1]),
		.drv_byte(drv_reg[IDX_A1]),
		.en_bit(en_reg[SOS_EN_BIT[IDX_A1]]),
		.global_bias_kind(GLOBAL_BIAS_KIND),
		.src_sysref(OUT_SRC_SYSREF[IDX_A1]),
		.delay_ps(OUT_SYSREF_DELAY_PS[IDX_A1]),
		.powered(OUT_POWERED[IDX_A1]),
		.lvpecl(OUT_LVPECL[IDX_A1]),
		.ampl(OUT_AMPLITUDE[IDX_A1]),
		.pass(OUT_PASS[IDX_A1]),
		.bias_on(OUT_BIAS_ON[IDX_A1])
	);

	sos_out_ctrl u_ctrl_a2 (
		.clk(CLK_SYS),
		.rst(RST),
		.dly_byte(dly_reg[IDX_A2]),
		.drv_byte(drv_reg[IDX_A2]),
		.en_bit(en_reg[SOS_EN_BIT[IDX_A2]]),
		.global_bias_kind(GLOBAL_BIAS_KIND),
		.src_sysref(OUT_SRC_SYSREF[IDX_A2]),
		.delay_ps(OUT_SYSREF_DELAY_PS[IDX_A2]),
		.powered(OUT_POWERED[IDX_A2]),
		.lvpecl(OUT_LVPECL[IDX_A2]),
		.ampl(OUT_AMPLITUDE[IDX_A2]),
		.pass(OUT_PASS[IDX_A2]),
		.bias_on(OUT_BIAS_ON[IDX_A2])
	);

	sos_out_ctrl u_ctrl_b0 (
		.clk(CLK_SYS),
		.rst(RST),
		.dly_byte(dly_reg[IDX_B0]),
		.drv_byte(drv_reg[IDX_B0]),
		.en_bit(en_reg[SOS_EN_BIT[IDX_B0]]),
		.global_bias_kind(GLOBAL_BIAS_KIND),
		.src_sysref(OUT_SRC_SYSREF[IDX_B0]),
		.delay_ps(OUT_SYSREF_DELAY_PS[IDX_B0]),
		.powered(OUT_POWERED[IDX_B0]),
		.lvpecl(OUT_LVPECL[IDX_B0]),
		.ampl(OUT_AMPLITUDE[IDX_B0]),
		.pass(OUT_PASS[IDX_B0]),
		.bias_on(OUT_BIAS_ON[IDX_B0])
	);

	sos_out_ctrl u_ctrl_b1 (
		.clk(CLK_SYS),
		.rst(RST),
		.dly_byte(dly_reg[IDX_B1]),
		.drv_byte(drv_reg[IDX_B1]),
		.en_bit(en_reg[SOS_EN_BIT[IDX_B1]]),
		.global_bias_kind(GLOBAL_BIAS_KIND),
		.src_sysref(OUT_SRC_SYSREF[IDX_B1]),
		.delay_ps(OUT_SYSREF_DELAY_PS[IDX_B1]),
		.powered(OUT_POWERED[IDX_B1]),
		.lvpecl(OUT_LVPECL[IDX_B1]),
		.ampl(OUT_AMPLITUDE[IDX_B1]),
		.pass(OUT_PASS[IDX_B1]),
		.bias_on(OUT_BIAS_ON[IDX_B1])
	);

	sos_out_ctrl u_ctrl_c (
		.clk(CLK_SYS),
		.rst(RST),
		.dly_byte(dly_reg[IDX_C]),
		.drv_byte(drv_reg[IDX_C]),
		.en_bit(en_reg[SOS_EN_BIT[IDX_C]]),
		.global_bias_kind(GLOBAL_BIAS_KIND),
		.src_sysref(OUT_SRC_SYSREF[IDX_C]),
		.delay_ps(OUT_SYSREF_DELAY_PS[IDX_C]),
		.powered(OUT_POWERED[IDX_C]),
		.lvpecl(OUT_LVPECL[IDX_C]),
		.ampl(OUT_AMPLITUDE[IDX_C]),
		.pass(OUT_PASS[IDX_C]),
		.bias_on(OUT_BIAS_ON[IDX_C])
	);

	sos_out_ctrl u_ctrl_d (
		.clk(CLK_SYS),
		.rst(RST),
		.dly_byte(dly_reg[IDX_D]),
		.drv_byte(drv_reg[IDX_D]),
		.en_bit(en_reg[SOS_EN_BIT[IDX_D]]),
		.global_bias_kind(GLOBAL_BIAS_KIND),
		.src_sysref(OUT_SRC_SYSREF[IDX_D]),
		.delay_ps(OUT_SYSREF_DELAY_PS[IDX_D]),
		.powered(OUT_POWERED[IDX_D]),
		.lvpecl(OUT_LVPECL[IDX_D]),
		.ampl(OUT_AMPLITUDE[IDX_D]),
		.pass(OUT_PASS[IDX_D]),
		.bias_on(OUT_BIAS_ON[IDX_D])
	);

endmodule // sos_regs

/* src/sos_pkg.sv */
/*
 * sos_pkg: register map, field layout, reset values and delay figures of the
 * reference-capable output state register bank.
 * assumes: byte-wide registers addressed by an 8-bit register address.
 */
package sos_pkg;

	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int SOS_NUM_OUT = 7;
	localparam int SOS_AW = 8;
	localparam int SOS_DW = 8;
	localparam int SOS_PS_W = 11;
	localparam int SOS_IDX_W = 3;

	// ---------------------------------------------------------------
	// register offsets, index 0..6 = a0, a1, a2, b0, b1, c, d
	// ---------------------------------------------------------------
	localparam logic [SOS_NUM_OUT-1:0][SOS_AW-1:0] SOS_DLY_ADDR = {
		8'h58, 8'h49, 8'h39, 8'h38, 8'h2a, 8'h29, 8'h28};
	localparam logic [SOS_NUM_OUT-1:0][SOS_AW-1:0] SOS_DRV_ADDR = {
		8'h5c, 8'h4d, 8'h3d, 8'h3c, 8'h2e, 8'h2d, 8'h2c};
	localparam logic [SOS_AW-1:0] SOS_EN_ADDR = 8'h76;

	// enable bit position of each output inside the shared enable register
	localparam logic [SOS_NUM_OUT-1:0][2:0] SOS_EN_BIT = {
		3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};

	// ---------------------------------------------------------------
	// delay/select register fields
	// ---------------------------------------------------------------
	localparam int SOS_FINE_HI_MSB = 6;
	localparam int SOS_FINE_HI_LSB = 5;
	localparam int SOS_SRC_BIT = 4;
	localparam int SOS_COARSE_MSB = 3;
	localparam int SOS_COARSE_LSB = 1;
	localparam int SOS_FINE_LO_BIT = 0;
	localparam logic [SOS_DW-1:0] SOS_DLY_MASK = 8'h7f;
	localparam logic [SOS_DW-1:0] SOS_DLY_RESET = 8'h10;

	// ---------------------------------------------------------------
	// driver register fields
	// ---------------------------------------------------------------
	localparam int SOS_PD_BIT = 7;
	localparam int SOS_BIAS_BIT = 5;
	localparam int SOS_STYLE_BIT = 4;
	localparam int SOS_AMP_MSB = 3;
	localparam int SOS_AMP_LSB = 2;
	localparam logic [SOS_DW-1:0] SOS_DRV_MASK = 8'hbc;
	localparam logic [SOS_DW-1:0] SOS_DRV_RESET = 8'h00;

	// ---------------------------------------------------------------
	// shared enable register
	// ---------------------------------------------------------------
	localparam logic [SOS_DW-1:0] SOS_EN_MASK = 8'hfb;
	localparam logic [SOS_DW-1:0] SOS_EN_RESET = 8'h00;

	// ---------------------------------------------------------------
	// delay figures in ps
	// ---------------------------------------------------------------
	localparam logic [SOS_PS_W-1:0] SOS_COARSE_STEP_PS = 11'h0a9;
	localparam logic [7:0][SOS_PS_W-1:0] SOS_FINE_PS = {
		11'h0a0, 11'h087, 11'h06e, 11'h055, 11'h04b, 11'h032, 11'h019, 11'h000};

	// index of a matching offset in a table, with a hit flag in the top bit
	function automatic logic [SOS_IDX_W:0] sos_find(
		input logic [SOS_AW-1:0] addr,
		input logic [SOS_NUM_OUT-1:0][SOS_AW-1:0] tbl);
		logic [SOS_IDX_W:0] res;
		res = '0;
		for (int i = 0; i < SOS_NUM_OUT; i++) begin
			if (tbl[i] == addr) begin
				res = {1'b1, SOS_IDX_W'(i)};
			end
		end
		return res;
	endfunction

endpackage

/* src/sos_out_ctrl.sv */
/*
 * sos_out_ctrl: turns the stored settings of one output into registered
 * control levels for the output driver and the sysref delay line.
 * assumes: settings bytes already have reserved bits cleared.
 */
`timescale 1ns/1ps
module sos_out_ctrl
	import sos_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// stored settings
	input wire logic [SOS_DW-1:0] dly_byte,
	input wire logic [SOS_DW-1:0] drv_byte,
	input wire logic en_bit,
	input wire logic global_bias_kind,
	// control levels
	output logic src_sysref,
	output logic [SOS_PS_W-1:0] delay_ps,
	output logic powered,
	output logic lvpecl,
	output logic [1:0] ampl,
	output logic pass,
	output logic bias_on
);

	// ---------------------------------------------------------------
	// field extraction
	// ---------------------------------------------------------------
	logic [2:0] coarse;
	logic [2:0] fine_code;
	logic pd;
	logic [SOS_PS_W-1:0] coarse_ps;

	assign coarse = dly_byte[SOS_COARSE_MSB:SOS_COARSE_LSB];
	// fine code is split: lower two bits high in the byte, bit two at the bottom
	assign fine_code = {dly_byte[SOS_FINE_LO_BIT], dly_byte[SOS_FINE_HI_MSB:SOS_FINE_HI_LSB]};
	assign pd = drv_byte[SOS_PD_BIT];
	assign coarse_ps = SOS_PS_W'(coarse * SOS_COARSE_STEP_PS);

	// ---------------------------------------------------------------
	// delay path
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			src_sysref <= 1'b1;
			delay_ps <= '0;
		end else begin
			src_sysref <= dly_byte[SOS_SRC_BIT];
			delay_ps <= SOS_PS_W'(coarse_ps + SOS_FINE_PS[fine_code]);
		end
	end

	// ---------------------------------------------------------------
	// driver path
	// ---------------------------------------------------------------
	// power-down masks format, enable and amplitude so the pad sees no stale setting
	always_ff @(posedge clk) begin
		if (rst) begin
			powered <= 1'b1;
			lvpecl <= 1'b0;
			ampl <= 2'h0;
			pass <= 1'b0;
		end else begin
			powered <= !pd;
			lvpecl <= !pd && drv_byte[SOS_STYLE_BIT];
			ampl <= pd ? 2'h0 : drv_byte[SOS_AMP_MSB:SOS_AMP_LSB];
			pass <= !pd && en_bit;
		end
	end

	// bias is not checked against coupling or format; software owns that
	always_ff @(posedge clk) begin
		if (rst) begin
			bias_on <= 1'b0;
		end else begin
			bias_on <= drv_byte[SOS_BIAS_BIT] && global_bias_kind;
		end
	end

endmodule // sos_out_ctrl

/* verif/sos_regs_assertions.sv */
/*
 * sos_regs_chk: port-level assertions for the output state bank.
 * assumes: bound into sos_regs, one clock domain.
 */
`timescale 1ns/1ps
module sos_regs_chk
	import sos_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// register port
	input wire logic REG_RD_EN,
	input wire logic [SOS_AW-1:0] REG_ADDR,
	input wire logic [SOS_DW-1:0] REG_RDATA,
	input wire logic REG_RVALID,
	// controls
	input wire logic GLOBAL_BIAS_KIND,
	input wire logic [SOS_NUM_OUT-1:0] OUT_SRC_SYSREF,
	input wire logic [SOS_NUM_OUT-1:0] OUT_POWERED,
	input wire logic [SOS_NUM_OUT-1:0] OUT_LVPECL,
	input wire logic [SOS_NUM_OUT-1:0][1:0] OUT_AMPLITUDE,
	input wire logic [SOS_NUM_OUT-1:0] OUT_PASS,
	input wire logic [SOS_NUM_OUT-1:0] OUT_BIAS_ON
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// -------------------------------------------
	// rules
	// -------------------------------------------
	a_read_answer: assert property (REG_RD_EN |=> REG_RVALID) else $error("read not answered");
	a_no_spurious: assert property (!REG_RD_EN |=> !REG_RVALID && $stable(REG_RDATA)) else $error("spurious read");
	a_en_reserved: assert property (REG_RD_EN && REG_ADDR == SOS_EN_ADDR |=> !REG_RDATA[2]) else $error("rsvd bit");
	a_pd_no_pass: assert property ((OUT_PASS & ~OUT_POWERED) == '0) else $error("pass while off");
	a_pd_no_fmt: assert property ((OUT_LVPECL & ~OUT_POWERED) == '0) else $error("format while off");
	a_bias_kind: assert property (!GLOBAL_BIAS_KIND |=> OUT_BIAS_ON == '0) else $error("bias without kind");
	a_reset_state: assert property ($fell(RST) |-> OUT_SRC_SYSREF == '1 && OUT_POWERED == '1) else $error("reset");
	for (genvar i = 0; i < SOS_NUM_OUT; i++) begin : g_amp
		a_amp_off: assert property (!OUT_POWERED[i] |-> OUT_AMPLITUDE[i] == 2'b00) else $error("amp while off");
	end
	c_read: cover property (REG_RVALID);
	c_pd: cover property (!OUT_POWERED[0]);
	c_bias: cover property (OUT_BIAS_ON != '0);
endmodule // sos_regs_chk

bind sos_regs sos_regs_chk chk_u (.CLK_SYS, .RST, .REG_RD_EN, .REG_ADDR, .REG_RDATA, .REG_RVALID,
	.GLOBAL_BIAS_KIND, .OUT_SRC_SYSREF, .OUT_POWERED, .OUT_LVPECL, .OUT_AMPLITUDE, .OUT_PASS, .OUT_BIAS_ON);

/* verif/tb.sv */
/*
 * tb: random register traffic with read-back and output checks.
 * assumes: sos_regs alone, strobes driven 1 ns after the edge.
 */
`timescale 1ns/1ps
module tb
	import sos_pkg::*;
;
	logic clk, rst, wr, rd, gbk, rvalid;
	logic [7:0] addr, wdata, rdata, r;
	logic [6:0] src, pwr, pecl, pass, bias;
	logic [6:0][10:0] dps;
	logic [6:0][1:0] amp;
	logic [7:0] dly_m[7], drv_m[7], en_m;
	logic [7:0] expq[$];
	int bad_count, checks_done;
	localparam logic [7:0][10:0] FINE = {11'h0a0, 11'h087, 11'h06e, 11'h055, 11'h04b, 11'h032, 11'h019, 11'h000};
	localparam int EN_POS[7] = '{7, 6, 5, 4, 3, 1, 0};

	sos_regs dut_u (.CLK_SYS(clk), .RST(rst), .REG_WR_EN(wr), .REG_RD_EN(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .REG_RVALID(rvalid), .GLOBAL_BIAS_KIND(gbk), .OUT_SRC_SYSREF(src),
		.OUT_SYSREF_DELAY_PS(dps), .OUT_POWERED(pwr), .OUT_LVPECL(pecl), .OUT_AMPLITUDE(amp),
		.OUT_PASS(pass), .OUT_BIAS_ON(bias));

	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	// -------------------------------------------
	// shared tasks
	// -------------------------------------------
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task print_verdict;
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// model of the register contents right after reset
	task automatic mdl_reset;
		en_m = 8'h00;
		for (int i = 0; i < 7; i++) begin
			dly_m[i] = 8'h10;
			drv_m[i] = 8'h00;
		end
	endtask

	// one gap cycle after each strobe keeps every assignment in its own step
	task automatic op(input logic w, input logic rr, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge clk);
		#1;
		wr = w;
		rd = rr;
		addr = a;
		wdata = d;
		if (rr) expq.push_back(e);
		@(posedge clk);
		#1;
		wr = 0;
		rd = 0;
	endtask

	task automatic rd_all;
		for (int i = 0; i < 7; i++) begin
			op(1'b0, 1'b1, SOS_DLY_ADDR[i], 8'h00, dly_m[i]);
			op(1'b0, 1'b1, SOS_DRV_ADDR[i], 8'h00, drv_m[i]);
		end
		op(1'b0, 1'b1, 8'h76, 8'h00, en_m);
		op(1'b0, 1'b1, 8'h2b, 8'h00, 8'h00);
	endtask

	task automatic chk_outs;
		logic p;
		for (int i = 0; i < 7; i++) begin
			p = !drv_m[i][7];
			cmp(src[i], dly_m[i][4]);
			cmp(dps[i], dly_m[i][3:1] * 11'h0a9 + FINE[{dly_m[i][0], dly_m[i][6:5]}]);
			cmp(pwr[i], p);
			cmp(pecl[i], p & drv_m[i][4]);
			cmp(amp[i], p ? drv_m[i][3:2] : 2'b00);
			cmp(pass[i], p & en_m[EN_POS[i]]);
			cmp(bias[i], drv_m[i][5] & gbk);
		end
	endtask
	// -------------------------------------------
	// read monitor and watchdog
	// -------------------------------------------
	initial forever begin
		@(posedge clk);
		#2;
		if (rvalid === 1'b1) begin
			if (expq.size() == 0) cmp(16'h0000, 16'h0001);
			else cmp(rdata, expq.pop_front());
		end
	end

	initial begin
		#2000000;
		bad_count++;
		print_verdict;
	end
	// -------------------------------------------
	// main sequence
	// -------------------------------------------
	initial begin
		rst = 1;
		wr = 0;
		rd = 0;
		addr = 0;
		wdata = 0;
		gbk = 0;
		bad_count = 0;
		checks_done = 0;
		mdl_reset;
		void'($urandom(23));
		repeat (6) @(posedge clk);
		#1;
		rst = 0;
		chk_outs;
		rd_all;
		op(1'b0, 1'b1, 8'h19, 8'h00, 8'h00);
		repeat (12) begin
			gbk = 1'($urandom);
			for (int i = 0; i < 7; i++) begin
				r = 8'($urandom);
				op(1'b1, 1'b0, SOS_DLY_ADDR[i], r, 8'h00);
				dly_m[i] = r & 8'h7f;
				r = 8'($urandom);
				// bias only with lvds; coupling is outside what the bench can see
				if (r[5]) r[4] = 1'b0;
				op(1'b1, 1'b0, SOS_DRV_ADDR[i], r, 8'h00);
				drv_m[i] = r & 8'hbc;
			end
			r = 8'($urandom);
			op(1'b1, 1'b0, 8'h76, r, 8'h00);
			en_m = r & 8'hfb;
			op(1'b1, 1'b0, 8'h2b, r, 8'h00);
			@(posedge clk);
			#1;
			chk_outs;
			rd_all;
		end
		// same-cycle write and read returns the old byte
		op(1'b1, 1'b1, 8'h76, 8'hff, en_m);
		en_m = 8'hfb;
		op(1'b0, 1'b1, 8'h76, 8'h00, en_m);
		// reset in mid-run must bring back the defaults over a random setup
		rst = 1;
		repeat (2) @(posedge clk);
		#1;
		rst = 0;
		mdl_reset;
		chk_outs;
		rd_all;
		repeat (3) @(posedge clk);
		print_verdict;
	end
endmodule // tb
